/* File: rtl/tslr_pkg.sv */
// package of offsets, reset values and command codes for the limit bank
package tslr_pkg;
	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam logic [3:0]  OFF_TIMER1_LIMIT  = 4'h0;
	localparam logic [3:0]  OFF_ADJUST_VALUE  = 4'h1;
	localparam logic [3:0]  OFF_LITERAL_WORD  = 4'h2;
	localparam logic [3:0]  OFF_SEQ_CONTROL   = 4'h3;
	localparam logic [3:0]  OFF_TIMER_LIMIT0  = 4'h4;
	localparam logic [3:0]  OFF_COUNTER_LIM0  = 4'h5;
	localparam logic [3:0]  OFF_COUNTER_LIM1  = 4'h6;
	localparam logic [3:0]  OFF_STEP_DELAY    = 4'h7;
	localparam logic [3:0]  OFF_ADC_CHANNEL   = 4'h8;
	// ---------------------------------------------------------------
	// control register fields
	// ---------------------------------------------------------------
	localparam int          BIT_ENABLE        = 0;
	localparam int          BIT_START         = 1;
	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [15:0] RST_VALUE         = 16'h0000;
	// ---------------------------------------------------------------
	// step commands
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		TSLR_CMD_TIMER1 = 2'b00,
		TSLR_CMD_ADD    = 2'b01,
		TSLR_CMD_CTRL   = 2'b10,
		TSLR_CMD_OTHER  = 2'b11
	} tslr_cmd_t;
	// add targets
	typedef enum logic [2:0] {
		TSLR_TGT_TLIM0  = 3'b000,
		TSLR_TGT_TLIM1  = 3'b001,
		TSLR_TGT_CLIM0  = 3'b010,
		TSLR_TGT_CLIM1  = 3'b011,
		TSLR_TGT_SDLIM  = 3'b100,
		TSLR_TGT_LIT    = 3'b101
	} tslr_tgt_t;
endpackage : tslr_pkg

/* File: rtl/tslr_timer1.sv */
// second general purpose timer run by the timer1 step command
`timescale 1ns/1ps
module tslr_timer1 #(
	parameter int WIDTH = 16
) (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst,
	// control
	input  wire logic             start,
	input  wire logic [WIDTH-1:0] limit,
	// status
	output logic                  busy,
	output logic                  done
);
	logic [WIDTH-1:0] count;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			count <= '0;
			busy  <= 1'b0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start && !busy) begin
				count <= '0;
				busy  <= 1'b1;
			end else if (busy) begin
				if (count >= limit) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					count <= count + 1'b1;
				end
			end
		end
	end

	chk_timer_done_end: assert property (@(posedge clk_sys) // RULE2
		disable iff (rst)
		busy && count >= limit |=> done && !busy)
		else $error("timer did not finish at its limit");
endmodule : tslr_timer1

/* File: rtl/tslr_bank.sv */
// limit, adjust and literal register bank of the trigger sequencer
// How it works
// RULE1 - second timer limit is 16-bit read/write, cleared at reset
// RULE2 - only the timer1 step command uses the second timer limit
// RULE3 - limit, adjust, literal writes ignored while enabled and started
// RULE4 - adjust value is 16-bit read/write, cleared at reset
// RULE5 - add command adds adjust to selected limit or literal
// RULE6 - literal is 16-bit read/write, control step copies it to adc
// RULE7 - add result is cut to 16 bits, carry dropped
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module tslr_bank (
	// clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 rst,
	// register port
	input  wire logic [3:0]           reg_addr,
	input  wire logic [15:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic      [15:0]          reg_rdata,
	// step command from the sequencer core
	input  wire logic                 cmd_valid,
	input  wire tslr_pkg::tslr_cmd_t  cmd_code,
	input  wire tslr_pkg::tslr_tgt_t  cmd_target,
	// results
	output logic      [15:0]          adc_channel_select,
	output logic                      timer1_busy,
	output logic                      timer1_done
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [15:0] step_timer1_limit;
	logic [15:0] limit_adjust_value;
	logic [15:0] literal_channel_word;
	logic [15:0] timer0_limit;
	logic [15:0] counter0_limit;
	logic [15:0] counter1_limit;
	logic [15:0] step_delay_limit;
	logic        sequencer_enable;
	logic        sequencer_start;
	logic        locked;
	logic        t1_busy;
	logic        t1_done;
	logic        run_timer1;

	function automatic logic [15:0] add16(input logic [15:0] a,
	                                       input logic [15:0] b);
		add16 = 16'(a + b); // RULE7
	endfunction : add16

	function automatic logic wr_hit(input logic [3:0] off);
		wr_hit = reg_wr && reg_addr == off && !locked; // RULE3
	endfunction : wr_hit

	function automatic logic add_hit(input tslr_pkg::tslr_tgt_t t);
		add_hit = cmd_valid && cmd_code == tslr_pkg::TSLR_CMD_ADD
		          && cmd_target == t;
	endfunction : add_hit

	assign locked = sequencer_enable && sequencer_start; // RULE3

	// ---------------------------------------------------------------
	// control bits (never locked, so software can stop the sequencer)
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sequencer_enable <= 1'b0;
			sequencer_start  <= 1'b0;
		end else if (reg_wr && reg_addr == tslr_pkg::OFF_SEQ_CONTROL) begin
			sequencer_enable <= reg_wdata[tslr_pkg::BIT_ENABLE];
			sequencer_start  <= reg_wdata[tslr_pkg::BIT_START];
		end
	end

	// ---------------------------------------------------------------
	// limit registers: software writes when unlocked, add when no write hits
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			step_timer1_limit <= tslr_pkg::RST_VALUE; // RULE1
		end else if (wr_hit(tslr_pkg::OFF_TIMER1_LIMIT)) begin
			step_timer1_limit <= reg_wdata; // RULE1
		end else if (add_hit(tslr_pkg::TSLR_TGT_TLIM1)) begin
			step_timer1_limit <= add16(step_timer1_limit,
			                           limit_adjust_value); // RULE5
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			timer0_limit <= tslr_pkg::RST_VALUE;
		end else if (wr_hit(tslr_pkg::OFF_TIMER_LIMIT0)) begin
			timer0_limit <= reg_wdata;
		end else if (add_hit(tslr_pkg::TSLR_TGT_TLIM0)) begin
			timer0_limit <= add16(timer0_limit, limit_adjust_value); // RULE5
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			counter0_limit <= tslr_pkg::RST_VALUE;
			counter1_limit <= tslr_pkg::RST_VALUE;
		end else begin
			if (wr_hit(tslr_pkg::OFF_COUNTER_LIM0)) begin
				counter0_limit <= reg_wdata;
			end else if (add_hit(tslr_pkg::TSLR_TGT_CLIM0)) begin
				counter0_limit <= add16(counter0_limit, limit_adjust_value); // RULE5
			end
			if (wr_hit(tslr_pkg::OFF_COUNTER_LIM1)) begin
				counter1_limit <= reg_wdata;
			end else if (add_hit(tslr_pkg::TSLR_TGT_CLIM1)) begin
				counter1_limit <= add16(counter1_limit, limit_adjust_value); // RULE5
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			step_delay_limit <= tslr_pkg::RST_VALUE;
		end else if (wr_hit(tslr_pkg::OFF_STEP_DELAY)) begin
			step_delay_limit <= reg_wdata;
		end else if (add_hit(tslr_pkg::TSLR_TGT_SDLIM)) begin
			step_delay_limit <= add16(step_delay_limit,
			                          limit_adjust_value); // RULE5
		end
	end

	// ---------------------------------------------------------------
	// adjust and literal
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			limit_adjust_value <= tslr_pkg::RST_VALUE; // RULE4
		end else if (wr_hit(tslr_pkg::OFF_ADJUST_VALUE)) begin
			limit_adjust_value <= reg_wdata; // RULE4
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			literal_channel_word <= tslr_pkg::RST_VALUE; // RULE6
		end else if (wr_hit(tslr_pkg::OFF_LITERAL_WORD)) begin
			literal_channel_word <= reg_wdata; // RULE6
		end else if (add_hit(tslr_pkg::TSLR_TGT_LIT)) begin
			literal_channel_word <= add16(literal_channel_word,
			                              limit_adjust_value); // RULE5
		end
	end

	// control step copies the whole literal into the channel select
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			adc_channel_select <= tslr_pkg::RST_VALUE;
		end else if (cmd_valid && cmd_code == tslr_pkg::TSLR_CMD_CTRL) begin
			adc_channel_select <= literal_channel_word; // RULE6
		end
	end

	// ---------------------------------------------------------------
	// second timer: only its own step command starts it
	// ---------------------------------------------------------------
	assign run_timer1 = cmd_valid && cmd_code == tslr_pkg::TSLR_CMD_TIMER1; // RULE2

	tslr_timer1 #(
		.WIDTH (16)
	) u_timer1 (
		.clk_sys (clk_sys),
		.rst     (rst),
		.start   (run_timer1),
		.limit   (step_timer1_limit),
		.busy    (t1_busy),
		.done    (t1_done)
	);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			timer1_busy <= 1'b0;
			timer1_done <= 1'b0;
		end else begin
			timer1_busy <= t1_busy;
			timer1_done <= t1_done;
		end
	end

	// ---------------------------------------------------------------
	// read port: data in the cycle after the strobe, zero elsewhere
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				tslr_pkg::OFF_TIMER1_LIMIT: reg_rdata <= step_timer1_limit;
				tslr_pkg::OFF_ADJUST_VALUE: reg_rdata <= limit_adjust_value;
				tslr_pkg::OFF_LITERAL_WORD: reg_rdata <= literal_channel_word;
				tslr_pkg::OFF_SEQ_CONTROL:  reg_rdata <= {14'h0000,
				                            sequencer_start, sequencer_enable};
				tslr_pkg::OFF_TIMER_LIMIT0: reg_rdata <= timer0_limit;
				tslr_pkg::OFF_COUNTER_LIM0: reg_rdata <= counter0_limit;
				tslr_pkg::OFF_COUNTER_LIM1: reg_rdata <= counter1_limit;
				tslr_pkg::OFF_STEP_DELAY:   reg_rdata <= step_delay_limit;
				tslr_pkg::OFF_ADC_CHANNEL:  reg_rdata <= adc_channel_select;
				default:                    reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	chk_reset_limit_zero: assert property (@(posedge clk_sys) // RULE1
		$rose(!rst) |-> step_timer1_limit == 16'h0000)
		else $error("timer1 limit not zero after reset");
	chk_timer1_only_cmd: assert property (@(posedge clk_sys) // RULE2
		disable iff (rst)
		!t1_busy && cmd_valid && cmd_code != tslr_pkg::TSLR_CMD_TIMER1
		|=> !t1_busy)
		else $error("timer started by another command");
	chk_locked_no_write: assert property (@(posedge clk_sys) // RULE3
		disable iff (rst)
		locked && reg_wr && !cmd_valid |=> $stable(limit_adjust_value)
		&& $stable(literal_channel_word) && $stable(step_timer1_limit))
		else $error("locked register changed on write");
	chk_adjust_written: assert property (@(posedge clk_sys) // RULE4
		disable iff (rst)
		!locked && reg_wr && reg_addr == tslr_pkg::OFF_ADJUST_VALUE
		|=> limit_adjust_value == $past(reg_wdata))
		else $error("adjust value not written");
	chk_add_literal: assert property (@(posedge clk_sys) // RULE5
		disable iff (rst)
		locked && add_hit(tslr_pkg::TSLR_TGT_LIT) |=> literal_channel_word
		== 16'($past(literal_channel_word) + $past(limit_adjust_value)))
		else $error("literal add wrong");
	chk_ctrl_copy: assert property (@(posedge clk_sys) // RULE6
		disable iff (rst)
		cmd_valid && cmd_code == tslr_pkg::TSLR_CMD_CTRL
		|=> adc_channel_select == $past(literal_channel_word))
		else $error("channel select not copied");
	// every add to the timer1 limit that no write overrides, so the overflowing sums are seen
	chk_add_wraps: assert property (@(posedge clk_sys) // RULE7
		disable iff (rst)
		add_hit(tslr_pkg::TSLR_TGT_TLIM1)
		&& !wr_hit(tslr_pkg::OFF_TIMER1_LIMIT)
		|=> step_timer1_limit == 16'($past(step_timer1_limit)
		+ $past(limit_adjust_value)))
		else $error("add carry not dropped");
	chk_read_latency: assert property (@(posedge clk_sys) // RULE6
		disable iff (rst)
		reg_rd && reg_addr == tslr_pkg::OFF_LITERAL_WORD && !reg_wr
		&& !cmd_valid |=> reg_rdata == $past(literal_channel_word))
		else $error("read data wrong");

	cov_locked_write: cover property (@(posedge clk_sys) locked && reg_wr);
	cov_add_cmd: cover property (@(posedge clk_sys)
		add_hit(tslr_pkg::TSLR_TGT_TLIM1));
	cov_ctrl_cmd: cover property (@(posedge clk_sys)
		cmd_valid && cmd_code == tslr_pkg::TSLR_CMD_CTRL);
	cov_timer_done: cover property (@(posedge clk_sys) t1_done);
endmodule : tslr_bank

/* File: dv/tslr_bank_tb.sv */
// self-checking bench for the limit, adjust and literal register bank
`timescale 1ns/1ps
`define CHK(got, exp) begin \
	n_compared++; \
	if ((got) !== (exp)) begin \
		mismatches++; \
		$display("ERROR %0t: got %h expected %h", $time, got, exp); \
	end \
end
module tslr_bank_tb;
	// ---------------------------------------------------------------
	// stimulus and observation
	// ---------------------------------------------------------------
	logic                 clk_sys    = 1'b0;
	logic                 rst        = 1'b1;
	logic [3:0]           reg_addr   = 4'h0;
	logic [15:0]          reg_wdata  = 16'h0000;
	logic                 reg_wr     = 1'b0;
	logic                 reg_rd     = 1'b0;
	logic [15:0]          reg_rdata;
	logic                 cmd_valid  = 1'b0;
	tslr_pkg::tslr_cmd_t  cmd_code   = tslr_pkg::TSLR_CMD_OTHER;
	tslr_pkg::tslr_tgt_t  cmd_target = tslr_pkg::TSLR_TGT_TLIM0;
	logic [15:0]          adc_channel_select;
	logic                 timer1_busy;
	logic                 timer1_done;
	int                   mismatches = 0;
	int                   n_compared = 0;
	int                   n_short;
	int                   n_long;
	// offsets in add-target order
	logic [3:0]           tgt_off [6] = '{tslr_pkg::OFF_TIMER_LIMIT0,
	                                      tslr_pkg::OFF_TIMER1_LIMIT,
	                                      tslr_pkg::OFF_COUNTER_LIM0,
	                                      tslr_pkg::OFF_COUNTER_LIM1,
	                                      tslr_pkg::OFF_STEP_DELAY,
	                                      tslr_pkg::OFF_LITERAL_WORD};

	always #2.5 clk_sys = ~clk_sys;

	tslr_bank u_tslr_bank (
		.clk_sys            (clk_sys),
		.rst                (rst),
		.reg_addr           (reg_addr),
		.reg_wdata          (reg_wdata),
		.reg_wr             (reg_wr),
		.reg_rd             (reg_rd),
		.reg_rdata          (reg_rdata),
		.cmd_valid          (cmd_valid),
		.cmd_code           (cmd_code),
		.cmd_target         (cmd_target),
		.adc_channel_select (adc_channel_select),
		.timer1_busy        (timer1_busy),
		.timer1_done        (timer1_done)
	);

	// ---------------------------------------------------------------
	// access tasks
	// ---------------------------------------------------------------
	task end_sim;
		if (mismatches == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_sim

	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr    <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd   <= 1'b0;
		#1;
		`CHK(reg_rdata, exp)
	endtask : rd

	task cmd(input tslr_pkg::tslr_cmd_t c, input tslr_pkg::tslr_tgt_t t);
		@(posedge clk_sys);
		cmd_code   <= c;
		cmd_target <= t;
		cmd_valid  <= 1'b1;
		@(posedge clk_sys);
		cmd_valid  <= 1'b0;
		#1;
	endtask : cmd

	// cycles from start to done; bounded so a dead timer cannot hang
	task run_timer(output int n);
		logic seen_busy;
		seen_busy = 1'b0;
		cmd(tslr_pkg::TSLR_CMD_TIMER1, tslr_pkg::TSLR_TGT_TLIM0);
		for (n = 0; n < 200; n++) begin
			@(posedge clk_sys);
			#1;
			if (timer1_busy === 1'b1) seen_busy = 1'b1;
			if (timer1_done === 1'b1) break;
		end
		if (n == 200) begin
			mismatches++;
			$display("ERROR %0t: timer never finished", $time);
			end_sim();
		end
		`CHK(seen_busy, 1'b1)
		@(posedge clk_sys);
		#1;
		`CHK(timer1_done, 1'b0)
	endtask : run_timer

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		rd(tslr_pkg::OFF_TIMER1_LIMIT, tslr_pkg::RST_VALUE);
		rd(tslr_pkg::OFF_ADJUST_VALUE, tslr_pkg::RST_VALUE);
		rd(tslr_pkg::OFF_LITERAL_WORD, tslr_pkg::RST_VALUE);
		`CHK(adc_channel_select, 16'h0000)
		rd(4'hf, 16'h0000);
		wr(tslr_pkg::OFF_TIMER1_LIMIT, 16'ha55a);
		rd(tslr_pkg::OFF_TIMER1_LIMIT, 16'ha55a);
		wr(tslr_pkg::OFF_ADJUST_VALUE, 16'h8011);
		rd(tslr_pkg::OFF_ADJUST_VALUE, 16'h8011);
		wr(tslr_pkg::OFF_LITERAL_WORD, 16'h5aa5);
		rd(tslr_pkg::OFF_LITERAL_WORD, 16'h5aa5);
		cmd(tslr_pkg::TSLR_CMD_CTRL, tslr_pkg::TSLR_TGT_TLIM0);
		`CHK(adc_channel_select, 16'h5aa5)
		wr(tslr_pkg::OFF_ADC_CHANNEL, 16'h1234);
		rd(tslr_pkg::OFF_ADC_CHANNEL, 16'h5aa5);
		// every target, each sum overflowing 16 bits
		for (int i = 0; i < 6; i++) begin
			wr(tgt_off[i], 16'hfff0 + 16'(i));
			cmd(tslr_pkg::TSLR_CMD_ADD, tslr_pkg::tslr_tgt_t'(i));
			rd(tgt_off[i], 16'h8001 + 16'(i));
		end
		cmd(tslr_pkg::TSLR_CMD_CTRL, tslr_pkg::TSLR_TGT_TLIM0);
		`CHK(adc_channel_select, 16'h8006)
		// enable alone does not lock
		wr(tslr_pkg::OFF_SEQ_CONTROL, 16'h0001);
		wr(tslr_pkg::OFF_TIMER1_LIMIT, 16'h0011);
		rd(tslr_pkg::OFF_TIMER1_LIMIT, 16'h0011);
		wr(tslr_pkg::OFF_SEQ_CONTROL, 16'h0003);
		wr(tslr_pkg::OFF_TIMER1_LIMIT, 16'h0022);
		rd(tslr_pkg::OFF_TIMER1_LIMIT, 16'h0011);
		wr(tslr_pkg::OFF_ADJUST_VALUE, 16'h0022);
		rd(tslr_pkg::OFF_ADJUST_VALUE, 16'h8011);
		wr(tslr_pkg::OFF_LITERAL_WORD, 16'h0022);
		rd(tslr_pkg::OFF_LITERAL_WORD, 16'h8006);
		// the sequencer itself still updates while software is locked out
		cmd(tslr_pkg::TSLR_CMD_ADD, tslr_pkg::TSLR_TGT_LIT);
		rd(tslr_pkg::OFF_LITERAL_WORD, 16'h0017);
		wr(tslr_pkg::OFF_SEQ_CONTROL, 16'h0000);
		wr(tslr_pkg::OFF_TIMER1_LIMIT, 16'h0004);
		run_timer(n_short);
		wr(tslr_pkg::OFF_TIMER1_LIMIT, 16'h000c);
		run_timer(n_long);
		`CHK(n_long - n_short, 8)
		cmd(tslr_pkg::TSLR_CMD_OTHER, tslr_pkg::TSLR_TGT_TLIM1);
		cmd(tslr_pkg::TSLR_CMD_CTRL, tslr_pkg::TSLR_TGT_TLIM1);
		`CHK(adc_channel_select, 16'h0017)
		repeat (4) @(posedge clk_sys);
		#1;
		`CHK(timer1_busy, 1'b0)
		end_sim();
	end
endmodule : tslr_bank_tb
